/* File: hdl/spb_device.sv */
// speech playback device: serial command intake, power state and per-channel playback sequencing
// Operation
// - oscillator stays stopped until power-up command
// - reset pin while waiting acts as power-down
// - busy low for command interval plus phrase
// - host chains next play within window
// - host chains next start within window
// - host chains silence or play within window
// - host sends repeat-set within window of start
// - acceptance low phase follows next command arrival
// - reject serial glitches up to spike limit
// - busy low while processing or channel playing
// - acceptance low while processing or request pending
// - command busy interval lasts at most limit
// - command enable window at most ten ms
`timescale 1ns/10ps
`include "spb_regs.svh"
module spb_device
  import spb_pkg::*;
#(
  parameter int CMD_BUSY_CYC    = `SPB_CMD_BUSY_CYC,
  parameter int CMD_WIN_CYC     = `SPB_CMD_WIN_CYC,
  parameter int PHRASE_UNIT_CYC = `SPB_PHRASE_UNIT_CYC,
  parameter int SPIKE_CYC       = `SPB_SPIKE_CYC
)
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // link to host
  spb_if.dev              link,
  // user side
  output logic            o_osc_run,
  output logic [1:0]      o_playing,
  output logic [1:0]      o_repeat,
  output logic            o_cmd_strobe,
  output logic [7:0]      o_cmd_byte
);

  localparam int CW = 24;
  localparam logic [3:0] PIN_IDLE = `SPB_PIN_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and spike filters

  logic [3:0] pin_raw;
  logic [3:0] pin_f;

  assign pin_raw = {link.reset_in_low, link.sel_n, link.ser_data, link.ser_clk};

  for (genvar g = 0; g < 4; g++)
  begin : g_pin
    logic [2:0] sync_q;
    logic [4:0] cnt_q;
    logic       filt_q;

    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        sync_q <= {3{PIN_IDLE[g]}};
      end
      else
      begin
        sync_q <= {sync_q[1:0], pin_raw[g]};
      end
    end

    // a level must hold longer than the spike limit before it counts
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        cnt_q  <= 5'h00;
        filt_q <= PIN_IDLE[g];
      end
      else if ((sync_q[1] == sync_q[2]) && (sync_q[2] != filt_q))
      begin
        if (cnt_q == 5'(SPIKE_CYC - 1))
        begin
          filt_q <= sync_q[2];
          cnt_q  <= 5'h00;
        end
        else
        begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
      else
      begin
        cnt_q <= 5'h00;
      end
    end

    assign pin_f[g] = filt_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial byte intake, msb first on rising serial clock

  logic       clk_prev_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic       cmd_v;
  logic [7:0] cmd_b;

  assign cmd_v = pin_f[0] && !clk_prev_q && !pin_f[2] && (bit_cnt_q == 3'h7);
  assign cmd_b = {shift_q, pin_f[1]};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      clk_prev_q <= 1'b0;
      bit_cnt_q  <= 3'h0;
      shift_q    <= 7'h00;
    end
    else
    begin
      clk_prev_q <= pin_f[0];
      if (pin_f[2])
      begin
        bit_cnt_q <= 3'h0;
      end
      else if (pin_f[0] && !clk_prev_q)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q   <= {shift_q[5:0], pin_f[1]};
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cmd_strobe <= 1'b0;
      o_cmd_byte   <= 8'h00;
    end
    else
    begin
      o_cmd_strobe <= cmd_v;
      if (cmd_v)
      begin
        o_cmd_byte <= cmd_b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state and command busy interval

  logic [3:0] op;
  logic       pwr_on;
  logic       go_down;
  logic       cmd_ok;
  logic       proc;
  spb_pwr_t   pwr_q;
  logic [CW-1:0] cb_cnt_q;

  assign op      = cmd_b[`SPB_OP_MSB:`SPB_OP_LSB];
  assign pwr_on  = (pwr_q == SPB_PWR_ON);
  assign cmd_ok  = cmd_v && (pwr_on || (op == `SPB_OP_POWER_UP));
  assign go_down = pwr_on && ((cmd_v && (op == `SPB_OP_POWER_DOWN)) || !pin_f[3]);
  assign proc    = (cb_cnt_q != '0);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pwr_q <= SPB_PWR_OFF;
    end
    else
    begin
      case (pwr_q)
        SPB_PWR_OFF:
        begin
          if (cmd_v && (op == `SPB_OP_POWER_UP) && pin_f[3])
          begin
            pwr_q <= SPB_PWR_ON;
          end
        end
        SPB_PWR_ON:
        begin
          if (go_down)
          begin
            pwr_q <= SPB_PWR_OFF;
          end
        end
        default:
        begin
          pwr_q <= SPB_PWR_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || go_down)
    begin
      cb_cnt_q <= '0;
    end
    else if (cmd_ok)
    begin
      cb_cnt_q <= CW'(CMD_BUSY_CYC);
    end
    else if (proc)
    begin
      cb_cnt_q <= cb_cnt_q - CW'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_osc_run <= 1'b0;
    end
    else
    begin
      o_osc_run <= pwr_on && !go_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // playback channels

  logic [1:0] busy_d;
  logic [1:0] acc_d;
  logic [1:0] play_d;
  logic [1:0] rep_d;

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    spb_ch_t       st_q;
    logic          pend_q;
    logic [2:0]    pend_len_q;
    logic [2:0]    len_q;
    logic [CW-1:0] play_cnt_q;
    logic [CW-1:0] win_cnt_q;
    logic          loop_q;
    logic          mine;
    logic          chain;
    logic          in_win;
    logic          end_now;
    logic          start;
    logic          restart;
    logic [2:0]    start_len;

    assign mine    = cmd_ok && (cmd_b[`SPB_CH_BIT] == 1'(c));
    assign chain   = mine && ((op == `SPB_OP_PLAY) || (op == `SPB_OP_START) || (op == `SPB_OP_SILENCE));
    assign in_win  = (win_cnt_q < CW'(CMD_WIN_CYC));
    assign end_now = (st_q == SPB_CH_PLAY) && (play_cnt_q == CW'(1));
    // a late chain still waits for the phrase end, never cuts it
    assign start   = pend_q && (((st_q == SPB_CH_IDLE) && !proc) || end_now);
    assign restart = end_now && loop_q && !pend_q;
    assign start_len = restart ? len_q : pend_len_q;

    always_ff @(posedge i_clk)
    begin
      if (i_rst || go_down || (mine && (op == `SPB_OP_STOP)))
      begin
        st_q       <= SPB_CH_IDLE;
        len_q      <= 3'h0;
        play_cnt_q <= '0;
        win_cnt_q  <= '0;
      end
      else if (start || restart)
      begin
        st_q       <= SPB_CH_PLAY;
        len_q      <= start_len;
        play_cnt_q <= CW'((int'(start_len) + 1) * PHRASE_UNIT_CYC);
        win_cnt_q  <= '0;
      end
      else if (end_now)
      begin
        st_q       <= SPB_CH_IDLE;
        play_cnt_q <= '0;
      end
      else if (st_q == SPB_CH_PLAY)
      begin
        play_cnt_q <= play_cnt_q - CW'(1);
        if (in_win)
        begin
          win_cnt_q <= win_cnt_q + CW'(1);
        end
      end
    end

    // new request beats consumption of the old one in the same cycle
    always_ff @(posedge i_clk)
    begin
      if (i_rst || go_down || (mine && (op == `SPB_OP_STOP)))
      begin
        pend_q     <= 1'b0;
        pend_len_q <= 3'h0;
      end
      else if (chain)
      begin
        pend_q     <= 1'b1;
        pend_len_q <= (op == `SPB_OP_START) ? len_q : cmd_b[`SPB_LEN_MSB:`SPB_LEN_LSB];
      end
      else if (start)
      begin
        pend_q <= 1'b0;
      end
    end

    // repeat-set only lands while the window of the running phrase is open
    always_ff @(posedge i_clk)
    begin
      if (i_rst || go_down || (mine && ((op == `SPB_OP_STOP) || (op == `SPB_OP_REPEAT_CLEAR))))
      begin
        loop_q <= 1'b0;
      end
      else if (mine && (op == `SPB_OP_REPEAT_SET) && (st_q == SPB_CH_PLAY) && in_win)
      begin
        loop_q <= 1'b1;
      end
    end

    // a pending start counts as busy so the line does not blink high before playback
    assign busy_d[c] = !(proc || pend_q || (st_q == SPB_CH_PLAY));
    assign acc_d[c]  = !(proc || pend_q);
    assign play_d[c] = (st_q == SPB_CH_PLAY);
    assign rep_d[c]  = loop_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      link.channel_busy_n <= 2'h3;
      link.cmd_accept_n   <= 2'h3;
      o_playing           <= 2'h0;
      o_repeat            <= 2'h0;
    end
    else
    begin
      link.channel_busy_n <= busy_d;
      link.cmd_accept_n   <= acc_d;
      o_playing           <= play_d;
      o_repeat            <= rep_d;
    end
  end

endmodule

/* File: hdl/spb_regs.svh */
// timing constants, command codes and pin defaults for the speech playback command link
`ifndef SPB_REGS_SVH
`define SPB_REGS_SVH

`define SPB_CLK_PERIOD_NS   4
`define SPB_CMD_BUSY_NS     2000000
`define SPB_CMD_BUSY_CYC    (`SPB_CMD_BUSY_NS / `SPB_CLK_PERIOD_NS)
`define SPB_CMD_WIN_NS      10000000
`define SPB_CMD_WIN_CYC     (`SPB_CMD_WIN_NS / `SPB_CLK_PERIOD_NS)
`define SPB_SPIKE_NS        50
`define SPB_SPIKE_CYC       ((`SPB_SPIKE_NS + `SPB_CLK_PERIOD_NS - 1) / `SPB_CLK_PERIOD_NS)
`define SPB_PHRASE_UNIT_CYC 250000
`define SPB_HALF_BIT_CYC    32

`define SPB_OP_POWER_UP     4'h0
`define SPB_OP_POWER_DOWN   4'h2
`define SPB_OP_STOP         4'h3
`define SPB_OP_PLAY         4'h4
`define SPB_OP_START        4'h5
`define SPB_OP_SILENCE      4'h6
`define SPB_OP_REPEAT_SET   4'h7
`define SPB_OP_REPEAT_CLEAR 4'h8
`define SPB_OP_CHAN_VOLUME  4'h9
`define SPB_OP_AMP_VOLUME   4'ha

`define SPB_OP_MSB          7
`define SPB_OP_LSB          4
`define SPB_LEN_MSB         3
`define SPB_LEN_LSB         1
`define SPB_CH_BIT          0

// pin order {reset_in_low, sel_n, ser_data, ser_clk}
`define SPB_PIN_IDLE        4'hc

`endif

/* File: hdl/spb_pkg.sv */
// types shared by both ends of the speech playback command link
package spb_pkg;

  typedef enum logic [0:0]
  {
    SPB_PWR_OFF = 1'b0,
    SPB_PWR_ON  = 1'b1
  } spb_pwr_t;

  typedef enum logic [0:0]
  {
    SPB_CH_IDLE = 1'b0,
    SPB_CH_PLAY = 1'b1
  } spb_ch_t;

  typedef enum logic [1:0]
  {
    SPB_H_IDLE  = 2'b00,
    SPB_H_LOW   = 2'b01,
    SPB_H_HIGH  = 2'b10,
    SPB_H_DESEL = 2'b11
  } spb_host_st_t;

endpackage

/* File: hdl/spb_if.sv */
// link between the playback device and its host
`timescale 1ns/10ps
interface spb_if;
  logic       ser_clk;
  logic       ser_data;
  logic       sel_n;
  logic       reset_in_low;
  logic [1:0] channel_busy_n;
  logic [1:0] cmd_accept_n;

  modport dev
  (
    input  ser_clk,
    input  ser_data,
    input  sel_n,
    input  reset_in_low,
    output channel_busy_n,
    output cmd_accept_n
  );

  modport host
  (
    output ser_clk,
    output ser_data,
    output sel_n,
    output reset_in_low,
    input  channel_busy_n,
    input  cmd_accept_n
  );
endinterface

/* File: hdl/spb_host.sv */
// host end: shifts command bytes out and watches channel status
`timescale 1ns/10ps
`include "spb_regs.svh"
module spb_host
  import spb_pkg::*;
#(
  parameter int HALF_BIT_CYC = `SPB_HALF_BIT_CYC
)
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // link to device
  spb_if.host             link,
  // user command port
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_byte,
  output logic            o_cmd_ready,
  input  wire logic       i_pin_reset,
  // status seen on the link
  output logic [1:0]      o_busy_n,
  output logic [1:0]      o_accept_n
);

  spb_host_st_t st_q;
  logic [7:0]   shift_q;
  logic [2:0]   bit_q;
  logic [7:0]   tick_q;
  logic         tick_end;

  assign tick_end = (tick_q == 8'(HALF_BIT_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // serial byte sender; the device samples on the rising clock

  always_ff @(posedge i_clk)
  begin
    if (i_rst || (st_q == SPB_H_IDLE) || tick_end)
    begin
      tick_q <= 8'h00;
    end
    else
    begin
      tick_q <= tick_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q          <= SPB_H_IDLE;
      shift_q       <= 8'h00;
      bit_q         <= 3'h0;
      o_cmd_ready   <= 1'b0;
      link.ser_clk  <= 1'b0;
      link.ser_data <= 1'b0;
      link.sel_n    <= 1'b1;
    end
    else
    begin
      case (st_q)
        SPB_H_IDLE:
        begin
          o_cmd_ready <= !(i_cmd_valid && o_cmd_ready);
          if (i_cmd_valid && o_cmd_ready)
          begin
            st_q          <= SPB_H_LOW;
            shift_q       <= {i_cmd_byte[6:0], 1'b0};
            bit_q         <= 3'h0;
            link.sel_n    <= 1'b0;
            link.ser_data <= i_cmd_byte[7];
          end
        end
        SPB_H_LOW:
        begin
          if (tick_end)
          begin
            st_q         <= SPB_H_HIGH;
            link.ser_clk <= 1'b1;
          end
        end
        SPB_H_HIGH:
        begin
          if (tick_end)
          begin
            link.ser_clk <= 1'b0;
            bit_q        <= bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              st_q <= SPB_H_DESEL;
            end
            else
            begin
              st_q          <= SPB_H_LOW;
              link.ser_data <= shift_q[7];
              shift_q       <= {shift_q[6:0], 1'b0};
            end
          end
        end
        SPB_H_DESEL:
        begin
          link.sel_n <= 1'b1;
          if (tick_end)
          begin
            st_q        <= SPB_H_IDLE;
            o_cmd_ready <= 1'b1;
          end
        end
        default:
        begin
          st_q <= SPB_H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      link.reset_in_low <= 1'b1;
    end
    else
    begin
      link.reset_in_low <= !i_pin_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status synchronisers: update once stages two and three agree

  logic [3:0] st_raw;
  logic [2:0] sync_q [4];

  assign st_raw = {link.cmd_accept_n, link.channel_busy_n};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 4; k++)
      begin
        sync_q[k] <= 3'h7;
      end
      o_busy_n   <= 2'h3;
      o_accept_n <= 2'h3;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        sync_q[k] <= {sync_q[k][1:0], st_raw[k]};
      end
      for (int k = 0; k < 2; k++)
      begin
        if (sync_q[k][1] == sync_q[k][2])
        begin
          o_busy_n[k] <= sync_q[k][2];
        end
        if (sync_q[k+2][1] == sync_q[k+2][2])
        begin
          o_accept_n[k] <= sync_q[k+2][2];
        end
      end
    end
  end

endmodule

/* File: verif/spb_link_sva.sv */
// concurrent checks on the playback command link
`timescale 1ns/10ps
module spb_link_sva
#(
  parameter int CB_CYC = 20,
  parameter int HB_CYC = 32
)
(
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // host to device
  input wire logic       ser_clk,
  input wire logic       ser_data,
  input wire logic       sel_n,
  input wire logic       reset_in_low,
  // device to host
  input wire logic [1:0] channel_busy_n,
  input wire logic [1:0] cmd_accept_n
);
  int unsigned acnt_q;
  int unsigned hcnt_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // run lengths of command busy and of the serial clock high phase
  always_ff @(posedge i_clk)
  begin
    if (i_rst || cmd_accept_n != 2'b00)
      acnt_q <= 0;
    else
      acnt_q <= acnt_q + 1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !ser_clk)
      hcnt_q <= 0;
    else
      hcnt_q <= hcnt_q + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence pin_low_s;
    !reset_in_low [*8] ##1 !reset_in_low [*8];
  endsequence

  sequence cmd_busy_s;
    (cmd_accept_n == 2'b00) [*8];
  endsequence

  rst_status_a: assert property ($fell(i_rst) |-> channel_busy_n == 2'b11 && cmd_accept_n == 2'b11)
    else $error("status not idle after reset");
  pin_reset_a: assert property (pin_low_s |-> ##[1:8] (channel_busy_n == 2'b11 && cmd_accept_n == 2'b11))
    else $error("reset pin did not power down");
  accept_busy0_a: assert property (!cmd_accept_n[0] |-> !channel_busy_n[0])
    else $error("channel 0 accept low without busy");
  accept_busy1_a: assert property (!cmd_accept_n[1] |-> !channel_busy_n[1])
    else $error("channel 1 accept low without busy");
  cb_len_a: assert property (acnt_q <= CB_CYC + 2)
    else $error("command busy too long");
  busy_start_a: assert property ($fell(channel_busy_n[0]) |-> cmd_accept_n == 2'b00 ##1 cmd_busy_s)
    else $error("busy began without command busy");
  idle_clk_a: assert property (sel_n |-> !ser_clk)
    else $error("serial clock high while deselected");
  bit_stable_a: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data))
    else $error("data moved while clock high");
  clk_high_a: assert property ($fell(ser_clk) |-> hcnt_q == HB_CYC)
    else $error("clock high phase wrong length");

  chain_c: cover property (!cmd_accept_n[0] && !channel_busy_n[0] && cmd_accept_n[1]);
endmodule

/* File: verif/speech_playback_command_sequencing_test.sv */
// self-checking bench: host and device joined, plus a device fed with glitches
`timescale 1ns/10ps
module speech_playback_command_sequencing_test;
  import spb_pkg::*;
  localparam int CB = 20;
  localparam int WIN = 500;
  localparam int PU = 400;
  localparam int HB = 16;

  logic       i_clk;
  logic       i_rst;
  logic       i_cmd_valid;
  logic [7:0] i_cmd_byte;
  logic       i_pin_reset;
  logic       o_cmd_ready;
  logic [1:0] o_busy_n;
  logic [1:0] o_accept_n;
  logic       o_osc_run;
  logic [1:0] o_playing;
  logic [1:0] o_repeat;
  logic       o_cmd_strobe;
  logic [7:0] o_cmd_byte;
  logic       b_strobe;
  logic [7:0] b_byte;
  logic [7:0] exp_q[$];
  int         errors;
  int         num_checks;
  int         seed;
  int         n;
  int         i;
  logic [7:0] c1_t[3] = '{8'h40, 8'h4e, 8'h60};
  logic [7:0] c2_t[3] = '{8'h42, 8'h40, 8'h40};
  int         gap_t[3] = '{0, 700, 0};
  int         len_t[3] = '{CB + 3 * PU, CB + 9 * PU, CB + 2 * PU};

  spb_if link_a();
  spb_if link_b();

  spb_host #(.HALF_BIT_CYC(HB)) spb_host_i
  (.i_clk, .i_rst, .link(link_a.host), .i_cmd_valid, .i_cmd_byte, .o_cmd_ready, .i_pin_reset, .o_busy_n, .o_accept_n);

  spb_device #(.CMD_BUSY_CYC(CB), .CMD_WIN_CYC(WIN), .PHRASE_UNIT_CYC(PU)) spb_device_i
  (.i_clk, .i_rst, .link(link_a.dev), .o_osc_run, .o_playing, .o_repeat, .o_cmd_strobe, .o_cmd_byte);

  spb_device #(.CMD_BUSY_CYC(CB), .CMD_WIN_CYC(WIN), .PHRASE_UNIT_CYC(PU)) spb_device_fault_i
  (.i_clk, .i_rst, .link(link_b.dev), .o_osc_run(), .o_playing(), .o_repeat(), .o_cmd_strobe(b_strobe),
   .o_cmd_byte(b_byte));

  spb_link_sva #(.CB_CYC(CB), .HB_CYC(HB)) spb_link_sva_i
  (.i_clk, .i_rst, .ser_clk(link_a.ser_clk), .ser_data(link_a.ser_data), .sel_n(link_a.sel_n),
   .reset_in_low(link_a.reset_in_low), .channel_busy_n(link_a.channel_busy_n), .cmd_accept_n(link_a.cmd_accept_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic near(input string what, input int e, input int g);
    num_checks++;
    if (g < e - 3 || g > e + 3)
    begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic idle(input int k);
    int t;
    t = 0;
    @(negedge i_clk);
    while (o_cmd_ready !== 1'b1 && t < 5000)
    begin
      @(negedge i_clk);
      t++;
    end
    repeat (k) @(negedge i_clk);
  endtask

  task automatic send(input logic [7:0] b);
    idle(0);
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_byte <= b;
    exp_q.push_back(b);
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
  endtask

  // busy low span of one channel, counted in cycles
  task automatic low_len(input int ch, output int len);
    int k;
    k = 0;
    len = 0;
    while (link_a.channel_busy_n[ch] !== 1'b0 && k < 3000)
    begin
      @(negedge i_clk);
      k++;
    end
    while (link_a.channel_busy_n[ch] === 1'b0 && len < 8000)
    begin
      @(negedge i_clk);
      len++;
    end
  endtask

  // one byte on the second link, a 12-cycle clock spike before each real pulse
  task automatic bang(input logic [7:0] b);
    int j;
    exp_q.push_back(b);
    @(posedge i_clk);
    link_b.sel_n <= 1'b0;
    for (j = 7; j >= 0; j--)
    begin
      link_b.ser_data <= b[j];
      repeat (4) @(posedge i_clk);
      link_b.ser_clk <= 1'b1;
      repeat (12) @(posedge i_clk);
      link_b.ser_clk <= 1'b0;
      repeat (24) @(posedge i_clk);
      link_b.ser_clk <= 1'b1;
      repeat (24) @(posedge i_clk);
      link_b.ser_clk <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    link_b.sel_n <= 1'b1;
    repeat (40) @(posedge i_clk);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // every received byte is compared with the oldest one sent
  always @(negedge i_clk)
  begin
    if (o_cmd_strobe === 1'b1)
      chk("received byte", (exp_q.size() > 0) ? exp_q.pop_front() : ~o_cmd_byte, o_cmd_byte);
    if (b_strobe === 1'b1)
      chk("filtered byte", (exp_q.size() > 0) ? exp_q.pop_front() : ~b_byte, b_byte);
  end

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial
  begin
    #240000;
    errors++;
    end_sim();
  end

  initial
  begin
    seed = 32'h4cd831fb;
    errors = 0;
    num_checks = 0;
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd_byte = 8'h00;
    i_pin_reset = 1'b0;
    link_b.ser_clk = 1'b0;
    link_b.ser_data = 1'b0;
    link_b.sel_n = 1'b1;
    link_b.reset_in_low = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 3; i++)
      send(8'h10 | 8'($random(seed)));
    idle(40);
    chk("osc before power-up", 8'h00, o_osc_run);
    chk("busy while off", 8'h03, o_busy_n);
    send(8'h00);
    idle(40);
    chk("osc after power-up", 8'h01, o_osc_run);
    fork
      low_len(1, n);
      send(8'h43);
    join
    near("play busy span", CB + 2 * PU, n);
    for (i = 0; i < 3; i++)
    begin
      fork
        low_len(0, n);
        begin
          send(c1_t[i]);
          repeat (gap_t[i]) @(negedge i_clk);
          send(c2_t[i]);
        end
      join
      near("chained busy span", len_t[i], n);
    end
    send(8'h41);
    send(8'h71);
    idle(100);
    chk("repeat set", 8'h02, o_repeat);
    chk("playing", 8'h02, o_playing);
    send(8'h81);
    send(8'h51);
    send(8'h91);
    send(8'ha0);
    idle(40);
    chk("repeat cleared", 8'h00, o_repeat);
    send(8'h31);
    idle(60);
    chk("stopped", 8'h00, o_playing);
    send(8'h20);
    idle(40);
    chk("osc after power-down", 8'h00, o_osc_run);
    send(8'h00);
    idle(40);
    send(8'h41);
    idle(10);
    @(posedge i_clk);
    i_pin_reset <= 1'b1;
    repeat (60) @(negedge i_clk);
    chk("osc after pin reset", 8'h00, o_osc_run);
    chk("busy after pin reset", 8'h03, link_a.channel_busy_n);
    chk("host accept after pin reset", 8'h03, o_accept_n);
    @(posedge i_clk);
    i_pin_reset <= 1'b0;
    bang(8'h5a);
    bang(8'ha5);
    chk("bytes outstanding", 8'h00, 8'(exp_q.size()));
    end_sim();
  end
endmodule
